// >>> shared/bcdrt_pkg.sv
// Constants and types shared by the calendar clock core
package bcdrt_pkg;
    localparam int unsigned NCNT = 7;
    localparam logic [2:0] A_SEC = 3'h0;
    localparam logic [2:0] A_MIN = 3'h1;
    localparam logic [2:0] A_HOUR = 3'h2;
    localparam logic [2:0] A_DAY = 3'h3;
    localparam logic [2:0] A_DATE = 3'h4;
    localparam logic [2:0] A_MONTH = 3'h5;
    localparam logic [2:0] A_YEAR = 3'h6;
    localparam logic [2:0] A_CAL = 3'h7;
    localparam logic [7:0] SLAVE_ADDR = 8'hd0;
    localparam int unsigned HALT_BIT = 7;
    localparam int unsigned SPARE_BIT = 7;
    localparam int unsigned CENT_HI = 7;
    localparam int unsigned CENT_LO = 6;
    localparam int unsigned MONTH_W = 5;
    localparam logic [7:0] FIELD_MASK [0:6] = '{8'h7f, 8'h7f, 8'h3f, 8'h07, 8'h3f, 8'h1f, 8'hff};
    localparam logic [7:0] FIELD_LO [0:6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
    localparam logic [7:0] FIELD_HI [0:6] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
    localparam logic [1:0] CENT_RST = 2'h0;
    localparam logic [7:0] CAL_RST = 8'h00;
    localparam logic [7:0] DAYS_28 = 8'h28;
    localparam logic [7:0] DAYS_29 = 8'h29;
    localparam logic [7:0] DAYS_30 = 8'h30;
    localparam logic [7:0] DAYS_31 = 8'h31;
    localparam logic [4:0] M_FEB = 5'h02;
    localparam logic [4:0] M_APR = 5'h04;
    localparam logic [4:0] M_JUN = 5'h06;
    localparam logic [4:0] M_SEP = 5'h09;
    localparam logic [4:0] M_NOV = 5'h11;
    localparam int unsigned OSC_FREQ_HZ = 32768;
    localparam int unsigned DIV_W = 15;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_FREQ_HZ - 1);
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ACK_ADDR, S_WORD, S_ACK_WORD, S_WDATA, S_ACK_DATA, S_RDATA, S_MACK
    } bcdrt_i2c_state_t;
endpackage

// >>> shared/bcdrt_cnt_if.sv
// Control and status bundle of one BCD time counter
`timescale 1ns/1ps
`default_nettype none
interface bcdrt_cnt_if;
    logic inc;
    logic load;
    logic [7:0] ld_val;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] val;
    logic wrap;
    modport ctrl (output inc, output load, output ld_val, output lo, output hi,
                  input val, input wrap);
    modport cnt (input inc, input load, input ld_val, input lo, input hi,
                 output val, output wrap);
endinterface
`default_nettype wire

// >>> design/bcdrt_bcd_cnt.sv
// One two-digit BCD counter with load and wrap
`timescale 1ns/1ps
`default_nettype none
module bcdrt_bcd_cnt #(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    // Counter bundle
    bcdrt_cnt_if.cnt bus
);
    logic [7:0] val_q;

    assign bus.val = val_q;
    assign bus.wrap = bus.inc && !bus.load && (val_q >= bus.hi);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            val_q <= RST_VAL;
        end else if (ce) begin
            if (bus.load) begin
                val_q <= bus.ld_val;
            end else if (bus.inc) begin
                // Also catches a value left above a shortened limit
                if (val_q >= bus.hi) begin
                    val_q <= bus.lo;
                end else if (val_q[3:0] == 4'h9) begin
                    val_q <= {val_q[7:4] + 4'h1, 4'h0};
                end else begin
                    val_q <= {val_q[7:4], val_q[3:0] + 4'h1};
                end
            end
        end
    end
endmodule // bcdrt_bcd_cnt
`default_nettype wire

// >>> design/bcdrt_core.sv
// Serial-bus BCD calendar clock core with slave interface and time chain
//
// Contract
// - Time and date live in eight BCD registers: second, minute, hour, day, date, century/month, year, calibration.
// - The register pointer advances by one after each data byte written and after each byte read that the master acknowledges.
// - Hours count 00 to 23 in BCD and then roll over.
// - Months end at 28, 29, 30 or 31 days, February following the leap year.
// - The seconds advance once per 32768 rising edges of the 32.768 kHz oscillator input.
// - Only the slave address D0h after a start is answered, then registers follow in sequence.
// - Bit 7 of register 0h halts the oscillator when 1 and lets it run when 0.
// - A write to registers 0h to 6h loads the running clock and clears the divider.
// - While a read addresses 0h to 6h, the readable copy is frozen until master NACK, stop or pointer 7h.
`timescale 1ns/1ps
`default_nettype none
module bcdrt_core (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    // Oscillator pin
    input wire logic osc_in,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_o,
    output logic sda_oe
);
    import bcdrt_pkg::*;

    logic [2:0] osc_sync_q;
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic [DIV_W-1:0] div_q;
    logic halt_q;
    logic spare_q;
    logic [1:0] century_q;
    logic [7:0] cal_q;
    logic [7:0] snap_q [0:6];
    bcdrt_i2c_state_t state_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [2:0] ptr_q;
    logic rw_q;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic osc_edge;
    logic tick;
    logic wr_stb;
    logic frozen;
    logic leap;
    logic [7:0] month_days;
    logic [7:0] rd_byte;
    logic [6:0] inc_v;
    logic [7:0] val_v [0:6];
    logic [6:0] wrap_v;

    bcdrt_cnt_if cif [NCNT] ();

    // Synchronisers: first stage feeds only the second
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            osc_sync_q <= 3'h0;
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else if (ce) begin
            osc_sync_q <= {osc_sync_q[1:0], osc_in};
            scl_sync_q <= {scl_sync_q[0], scl_in};
            sda_sync_q <= {sda_sync_q[0], sda_in};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    assign osc_edge = osc_sync_q[1] && !osc_sync_q[2];
    assign scl_rise = scl_sync_q[1] && !scl_prev_q;
    assign scl_fall = !scl_sync_q[1] && scl_prev_q;
    assign start_cond = scl_sync_q[1] && scl_prev_q && !sda_sync_q[1] && sda_prev_q;
    assign stop_cond = scl_sync_q[1] && scl_prev_q && sda_sync_q[1] && !sda_prev_q;

    // Data byte taken at the fall that ends its eighth bit
    assign wr_stb = (state_q == S_WDATA) && scl_fall && (bit_q == BYTE_BITS);

    // Divider: halted oscillator gives no edges to count
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= '0;
        end else if (ce) begin
            if (wr_stb && ptr_q != A_CAL) begin
                div_q <= '0;
            end else if (osc_edge && !halt_q) begin
                div_q <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
            end
        end
    end

    assign tick = osc_edge && !halt_q && (div_q == DIV_LAST) && !wr_stb;

    // Leap year from BCD year: divisible by four
    assign leap = val_v[A_YEAR][4] ? (val_v[A_YEAR][3:0] == 4'h2 || val_v[A_YEAR][3:0] == 4'h6)
                : (val_v[A_YEAR][3:0] == 4'h0 || val_v[A_YEAR][3:0] == 4'h4
                   || val_v[A_YEAR][3:0] == 4'h8);

    always_comb begin
        unique case (val_v[A_MONTH][MONTH_W-1:0])
            M_FEB: month_days = leap ? DAYS_29 : DAYS_28;
            M_APR, M_JUN, M_SEP, M_NOV: month_days = DAYS_30;
            default: month_days = DAYS_31;
        endcase
    end

    // Carry chain: day of week and date both step at midnight
    assign inc_v[A_SEC] = tick;
    assign inc_v[A_MIN] = wrap_v[A_SEC];
    assign inc_v[A_HOUR] = wrap_v[A_MIN];
    assign inc_v[A_DAY] = wrap_v[A_HOUR];
    assign inc_v[A_DATE] = wrap_v[A_HOUR];
    assign inc_v[A_MONTH] = wrap_v[A_DATE];
    assign inc_v[A_YEAR] = wrap_v[A_MONTH];

    genvar g;
    generate
        for (g = 0; g < NCNT; g++) begin : g_cnt
            assign cif[g].inc = inc_v[g];
            assign cif[g].load = wr_stb && (ptr_q == 3'(g));
            assign cif[g].ld_val = shift_q & FIELD_MASK[g];
            assign cif[g].lo = FIELD_LO[g];
            assign cif[g].hi = (g == A_DATE) ? month_days : FIELD_HI[g];
            assign val_v[g] = cif[g].val;
            assign wrap_v[g] = cif[g].wrap;
            bcdrt_bcd_cnt #(
                .RST_VAL(FIELD_LO[g])
            ) u_cnt (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .ce(ce),
                .bus(cif[g].cnt)
            );
        end
    endgenerate

    // Control bits sharing clock registers, plus calibration byte
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            halt_q <= 1'b0;
            spare_q <= 1'b0;
            century_q <= CENT_RST;
            cal_q <= CAL_RST;
        end else if (ce) begin
            if (wr_stb && ptr_q == A_SEC) begin
                halt_q <= shift_q[HALT_BIT];
            end
            if (wr_stb && ptr_q == A_MIN) begin
                spare_q <= shift_q[SPARE_BIT];
            end
            if (wr_stb && ptr_q == A_MONTH) begin
                century_q <= shift_q[CENT_HI:CENT_LO];
            end else if (wrap_v[A_YEAR]) begin
                century_q <= century_q + 2'h1;
            end
            if (wr_stb && ptr_q == A_CAL) begin
                cal_q <= shift_q;
            end
        end
    end

    // Readable copy holds still while a clock byte is being read out
    assign frozen = (state_q == S_RDATA || state_q == S_MACK) && (ptr_q != A_CAL);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NCNT; i++) begin
                snap_q[i] <= FIELD_LO[i];
            end
        end else if (ce && !frozen) begin
            for (int i = 0; i < NCNT; i++) begin
                snap_q[i] <= val_v[i];
            end
            snap_q[A_SEC][HALT_BIT] <= halt_q;
            snap_q[A_MIN][SPARE_BIT] <= spare_q;
            snap_q[A_MONTH][CENT_HI:CENT_LO] <= century_q;
        end
    end

    assign rd_byte = (ptr_q == A_CAL) ? cal_q : snap_q[ptr_q];

    // Serial slave: sample on SCL rise, change SDA after SCL fall
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= A_SEC;
            rw_q <= 1'b0;
        end else if (ce) begin
            if (start_cond) begin
                state_q <= S_ADDR;
                bit_q <= 4'h0;
            end else if (stop_cond) begin
                state_q <= S_IDLE;
            end else if (scl_rise) begin
                unique case (state_q)
                    S_ADDR, S_WORD, S_WDATA: begin
                        shift_q <= {shift_q[6:0], sda_sync_q[1]};
                        bit_q <= bit_q + 4'h1;
                    end
                    S_MACK: begin
                        if (sda_sync_q[1]) begin
                            state_q <= S_IDLE;
                        end else begin
                            ptr_q <= ptr_q + 3'h1;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                unique case (state_q)
                    S_ADDR: begin
                        if (bit_q == BYTE_BITS) begin
                            bit_q <= 4'h0;
                            if (shift_q[7:1] == SLAVE_ADDR[7:1]) begin
                                rw_q <= shift_q[0];
                                state_q <= S_ACK_ADDR;
                            end else begin
                                state_q <= S_IDLE;
                            end
                        end
                    end
                    S_WORD: begin
                        if (bit_q == BYTE_BITS) begin
                            bit_q <= 4'h0;
                            ptr_q <= shift_q[2:0];
                            state_q <= S_ACK_WORD;
                        end
                    end
                    S_WDATA: begin
                        if (bit_q == BYTE_BITS) begin
                            bit_q <= 4'h0;
                            ptr_q <= ptr_q + 3'h1;
                            state_q <= S_ACK_DATA;
                        end
                    end
                    S_ACK_ADDR: begin
                        if (rw_q) begin
                            shift_q <= rd_byte;
                            state_q <= S_RDATA;
                        end else begin
                            state_q <= S_WORD;
                        end
                    end
                    S_ACK_WORD, S_ACK_DATA: state_q <= S_WDATA;
                    S_RDATA: begin
                        if (bit_q == LAST_BIT) begin
                            bit_q <= 4'h0;
                            state_q <= S_MACK;
                        end else begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                    S_MACK: begin
                        shift_q <= rd_byte;
                        state_q <= S_RDATA;
                    end
                    S_IDLE: begin
                    end
                endcase
            end
        end
    end

    // Open drain: only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe = (state_q == S_ACK_ADDR) || (state_q == S_ACK_WORD)
                  || (state_q == S_ACK_DATA) || (state_q == S_RDATA && !shift_q[7]);
endmodule // bcdrt_core
`default_nettype wire

// >>> tb/bcdrt_core_asserts.sv
// Port-level checks of the calendar clock serial slave
`timescale 1ns/1ps
`default_nettype none
module bcdrt_core_asserts (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    // Pins
    input wire logic osc_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_o,
    input wire logic sda_oe
);
    import bcdrt_pkg::*;
    logic scl_q, sda_q, act_q, first_q, sel_q, rd_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    wire logic rise = scl_in && !scl_q;
    wire logic strt = scl_in && scl_q && sda_q && !sda_in;
    wire logic stp = scl_in && scl_q && !sda_q && sda_in;
    wire logic ack9 = rise && act_q && cnt_q == 4'h8;
    wire logic match = sh_q[7:1] == SLAVE_ADDR[7:1];
    // Own decode of the wire, so the checks never lean on internal state
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            {act_q, first_q, sel_q, rd_q} <= 4'h0;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            if (strt) begin
                {act_q, first_q, sel_q} <= 3'h6;
                cnt_q <= 4'h0;
            end else if (stp) begin
                act_q <= 1'b0;
            end else if (rise && cnt_q == 4'h8) begin
                cnt_q <= 4'h0;
                first_q <= 1'b0;
                if (first_q) begin
                    sel_q <= match;
                    rd_q <= sh_q[0];
                end
            end else if (rise) begin
                cnt_q <= cnt_q + 4'h1;
                sh_q <= {sh_q[6:0], sda_in};
            end
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    drain_low_a: assert property (sda_o == 1'b0)
        else $error("sda value not low");
    reset_quiet_a: assert property ($fell(sys_rst) |-> !sda_oe)
        else $error("sda driven after reset");
    oe_scl_low_a: assert property ($changed(sda_oe) |-> !scl_in && !scl_q)
        else $error("sda drive changed while scl high");
    addr_ack_a: assert property (ack9 && first_q && match |-> sda_oe)
        else $error("own address not acknowledged");
    addr_nack_a: assert property (ack9 && first_q && !match |-> !sda_oe)
        else $error("foreign address acknowledged");
    ack_time_a: assert property ($fell(scl_in) && act_q && !first_q && sel_q && !rd_q
        && cnt_q == 4'h8 |-> ##[1:6] sda_oe) else $error("write byte not acknowledged in time");
    rd_release_a: assert property (ack9 && !first_q && sel_q && rd_q |-> !sda_oe)
        else $error("slave drives master ack slot");
    idle_quiet_a: assert property (!act_q || (!first_q && !sel_q) |-> !sda_oe)
        else $error("sda driven while not addressed");
    enable_hold_a: assert property (!ce |=> $stable(sda_oe))
        else $error("sda drive moved while enable low");
endmodule // bcdrt_core_asserts
bind bcdrt_core bcdrt_core_asserts bcdrt_core_asserts_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .ce(ce), .osc_in(osc_in), .scl_in(scl_in), .sda_in(sda_in), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

// >>> tb/bcdrt_i2c_host.sv
// Serial bus master model for the calendar clock slave
`timescale 1ns/1ps
`default_nettype none
module bcdrt_i2c_host #(
    parameter int HP = 125
) (
    // Clock
    input wire logic clk_sys,
    // Bus wires
    input wire logic sda_in,
    output var logic scl,
    output var logic sda_pull
);
    localparam int SETUP = 10;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // Data moves well after SCL falls, so it never looks like start or stop
    task automatic bit_io(input logic b, output logic r);
        tick(SETUP);
        sda_pull = !b;
        tick(HP - SETUP);
        scl = 1'b1;
        tick(HP / 2);
        r = sda_in;
        tick(HP - HP / 2);
        scl = 1'b0;
    endtask
    task automatic start_c();
        if (!scl) begin
            tick(SETUP);
            sda_pull = 1'b0;
            tick(HP - SETUP);
            scl = 1'b1;
            tick(HP);
        end
        sda_pull = 1'b1;
        tick(HP);
        scl = 1'b0;
    endtask
    task automatic stop_c();
        tick(SETUP);
        sda_pull = 1'b1;
        tick(HP - SETUP);
        scl = 1'b1;
        tick(HP);
        sda_pull = 1'b0;
        tick(HP);
    endtask
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!ack, r);
    endtask
endmodule // bcdrt_i2c_host
`default_nettype wire

// >>> tb/bcdrt_core_bench.sv
// Self-checking bench for the calendar clock core
`timescale 1ns/1ps
`default_nettype none
module bcdrt_core_bench;
    import bcdrt_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic osc_in = 1'b0;
    logic scl, sda_pull, sda_o, sda_oe, ack;
    logic [1:0] cent;
    logic [7:0] bad, d;
    logic [7:0] wv [0:7];
    logic [7:0] ev [0:7];
    int err_count = 0;
    int n_tests = 0;
    // Pull-up: the wire is low whenever either side pulls
    wire logic sda_w = !(sda_oe || sda_pull);
    always #5 clk_sys = ~clk_sys;
    bcdrt_core bcdrt_core_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .osc_in(osc_in),
        .scl_in(scl), .sda_in(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
    bcdrt_i2c_host bcdrt_i2c_host_inst (.clk_sys(clk_sys), .sda_in(sda_w), .scl(scl),
        .sda_pull(sda_pull));
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic osc_rises(input int n);
        repeat (n) begin
            @(negedge clk_sys) osc_in = 1'b1;
            @(negedge clk_sys) osc_in = 1'b0;
        end
    endtask
    function automatic logic [7:0] next_dow(input logic [7:0] w);
        return (w == 8'h07) ? 8'h01 : w + 8'h01;
    endfunction
    // December wraps to January and the century steps with the year
    function automatic logic [7:0] next_month(input logic [1:0] c);
        return {c + 2'h1, 6'h01};
    endfunction
    initial begin
        repeat (125000) @(posedge clk_sys);
        err_count++;
        $display("watchdog expired");
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h92ab));
        cent = 2'($urandom_range(2, 0));
        wv = '{8'h59, 8'h59, 8'h23, 8'($urandom_range(7, 1)), 8'h31, {cent, 6'h12}, 8'h99,
            8'($urandom)};
        ev = '{8'h00, 8'h00, 8'h00, next_dow(wv[3]), 8'h01, next_month(cent), 8'h00, wv[7]};
        do bad = 8'($urandom); while (bad[7:1] == SLAVE_ADDR[7:1]);
        repeat (8) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (5) @(negedge clk_sys);
        // Last second of a century; edges counted during the burst must be
        // thrown away by the clock-register writes, the year byte last
        bcdrt_i2c_host_inst.start_c();
        fork
            osc_rises(8000);
            begin
                bcdrt_i2c_host_inst.wr_byte(SLAVE_ADDR, ack);
                chk("address ack", 8'h01, {7'h0, ack});
                bcdrt_i2c_host_inst.wr_byte(8'h00, ack);
                for (int i = 0; i < 7; i++) begin
                    bcdrt_i2c_host_inst.wr_byte(wv[i], ack);
                    chk("data ack", 8'h01, {7'h0, ack});
                end
            end
        join
        // Calibration byte leaves the divider alone, so it overlaps the count;
        // one edge falls while the enable is low and must be lost
        fork
            begin
                osc_rises(30000);
                ce = 1'b0;
                osc_rises(1);
                ce = 1'b1;
                osc_rises(2767);
            end
            begin
                bcdrt_i2c_host_inst.wr_byte(wv[7], ack);
                chk("data ack", 8'h01, {7'h0, ack});
                bcdrt_i2c_host_inst.stop_c();
                $display("write burst done");
                bcdrt_i2c_host_inst.start_c();
                bcdrt_i2c_host_inst.wr_byte(bad, ack);
                chk("foreign ack", 8'h00, {7'h0, ack});
                bcdrt_i2c_host_inst.stop_c();
                $display("foreign address done");
            end
        join
        // Pointer wrapped to 0; a NACKed read must leave it there
        bcdrt_i2c_host_inst.start_c();
        bcdrt_i2c_host_inst.wr_byte(SLAVE_ADDR | 8'h01, ack);
        bcdrt_i2c_host_inst.rd_byte(1'b0, d);
        chk("second early", 8'h59, d);
        bcdrt_i2c_host_inst.stop_c();
        $display("early read done");
        osc_rises(1);
        bcdrt_i2c_host_inst.start_c();
        bcdrt_i2c_host_inst.wr_byte(SLAVE_ADDR | 8'h01, ack);
        for (int i = 0; i < 8; i++) begin
            bcdrt_i2c_host_inst.rd_byte(i < 7, d);
            chk($sformatf("reg %0d", i), ev[i], d);
        end
        bcdrt_i2c_host_inst.stop_c();
        $display("rollover read done");
        report_and_stop();
    end
endmodule // bcdrt_core_bench
`default_nettype wire
